/* File: remote_response_status_framer.sv */
// builds remote command response and join trace frames onto a byte stream
module remote_response_status_framer
  import framer_pkg::*;
#(
  parameter int DATA_MAX = 32,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic verbose_join_option_i,
  input wire logic command_mode_i,
  input wire logic rsp_valid_i,
  output logic rsp_ready_o,
  input wire logic [7:0] rsp_frame_id_i,
  input wire logic [63:0] rsp_addr64_i,
  input wire logic [15:0] rsp_addr16_i,
  input wire logic rsp_addr16_known_i,
  input wire logic [15:0] rsp_cmd_name_i,
  input wire logic [7:0] rsp_status_i,
  input wire logic rsp_was_write_i,
  input wire logic [7:0] rsp_data_len_i,
  input wire logic [8*DATA_MAX-1:0] rsp_data_i,
  input wire logic trc_valid_i,
  output logic trc_ready_o,
  input wire logic [7:0] trc_code_i,
  input wire logic [7:0] join_attempt_count_i,
  input wire logic [7:0] stack_state_byte_i,
  input wire logic [7:0] network_event_byte_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i
);
  localparam logic [7:0] DATA_MAX_B = 8'(DATA_MAX);

  typedef struct packed {
    phase_e phase;
    logic is_rsp;
    logic [7:0] ftype;
    logic [7:0] fid;
    logic [63:0] addr64;
    logic [15:0] addr16;
    logic [15:0] name;
    logic [7:0] status;
    logic [7:0] data_base;
    logic [8*DATA_MAX-1:0] data;
    logic [15:0] len;
    logic [7:0] pos;
    logic [7:0] sum;
    logic offer_trc;
    logic rsp_ready;
    logic trc_ready;
    logic tx_valid;
    logic [7:0] tx_data;
  } framer_s;

  framer_s s_r;
  framer_s s_nxt;

  byte_stream_if #(.WIDTH(8)) fill_s ();
  byte_stream_if #(.WIDTH(8)) drain_s ();

  logic [7:0] text_char;
  logic text_last;
  logic [7:0] last_pos;
  logic [7:0] cur_byte;
  logic rsp_take;
  logic trc_take;
  logic [7:0] dlen;

  // byte at the current position of the frame being built
  function automatic logic [7:0] frame_byte(input framer_s s, input logic [7:0] last);
    logic [7:0] b;
    b = 8'h00;
    if (s.pos == POS_DELIM)
    begin
      b = START_DELIM;
    end
    else if (s.pos == POS_LEN_MSB)
    begin
      b = s.len[15:8];
    end
    else if (s.pos == POS_LEN_LSB)
    begin
      b = s.len[7:0];
    end
    else if (s.pos == last)
    begin
      b = CSUM_BASE - s.sum;
    end
    else if (s.pos == POS_TYPE)
    begin
      b = s.ftype;
    end
    else if (s.pos == POS_FRAME_ID)
    begin
      b = s.fid;
    end
    else if (s.is_rsp && s.pos <= POS_ADDR64_LSB)
    begin
      b = s.addr64[8*(POS_ADDR64_LSB - s.pos) +: 8];
    end
    else if (s.is_rsp && s.pos == POS_ADDR16_MSB)
    begin
      b = s.addr16[15:8];
    end
    else if (s.is_rsp && s.pos == POS_ADDR16_LSB)
    begin
      b = s.addr16[7:0];
    end
    else if (s.is_rsp && s.pos == POS_NAME_HI)
    begin
      b = s.name[15:8];
    end
    else if (s.is_rsp && s.pos == POS_NAME_LO)
    begin
      b = s.name[7:0];
    end
    else if (s.is_rsp && s.pos == POS_STATUS)
    begin
      b = s.status;
    end
    else
    begin
      b = s.data[8*(s.pos - s.data_base) +: 8];
    end
    return b;
  endfunction : frame_byte

  trace_text_rom u_text (
    .code_i(s_r.fid),
    .index_i(s_r.pos),
    .char_o(text_char),
    .last_o(text_last)
  );

  byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .in_s(fill_s),
    .out_s(drain_s)
  );

  assign last_pos = HDR_BYTES + s_r.len[7:0];
  assign cur_byte = frame_byte(s_r, last_pos);
  assign fill_s.valid = (s_r.phase != PH_IDLE);
  assign fill_s.data = (s_r.phase == PH_TEXT) ? text_char : cur_byte;
  assign drain_s.ready = !s_r.tx_valid || tx_ready_i;

  assign rsp_ready_o = s_r.rsp_ready;
  assign trc_ready_o = s_r.trc_ready;
  assign tx_valid_o = s_r.tx_valid;
  assign tx_data_o = s_r.tx_data;

  always_comb
  begin
    s_nxt = s_r;
    rsp_take = (s_r.phase == PH_IDLE) && s_r.rsp_ready && rsp_valid_i;
    trc_take = (s_r.phase == PH_IDLE) && s_r.trc_ready && trc_valid_i;
    // data field is dropped when the command wrote a setting
    dlen = rsp_was_write_i ? 8'h00 : ((rsp_data_len_i > DATA_MAX_B) ? DATA_MAX_B
                                                                    : rsp_data_len_i);
    s_nxt.offer_trc = !s_r.offer_trc;

    if (rsp_take)
    begin
      s_nxt.phase = PH_FRAME;
      s_nxt.is_rsp = 1'b1;
      s_nxt.ftype = TYPE_REMOTE_RSP;
      s_nxt.fid = rsp_frame_id_i;
      s_nxt.addr64 = rsp_addr64_i;
      s_nxt.addr16 = rsp_addr16_known_i ? rsp_addr16_i : ADDR16_UNKNOWN;
      s_nxt.name = rsp_cmd_name_i;
      s_nxt.status = rsp_status_i;
      s_nxt.data_base = POS_RSP_DATA;
      s_nxt.data = rsp_data_i;
      s_nxt.len = RSP_FIXED_LEN + {8'h00, dlen};
      s_nxt.pos = POS_DELIM;
      s_nxt.sum = 8'h00;
    end
    else if (trc_take)
    begin
      s_nxt.is_rsp = 1'b0;
      s_nxt.ftype = TYPE_TRACE;
      s_nxt.fid = trc_code_i;
      s_nxt.data_base = POS_TRC_DATA;
      s_nxt.data = '0;
      if (trc_code_i == TRC_JOIN_START)
      begin
        s_nxt.data[7:0] = join_attempt_count_i;
      end
      else if (trc_code_i == TRC_STACK_STATUS)
      begin
        s_nxt.data[7:0] = stack_state_byte_i;
        s_nxt.data[15:8] = network_event_byte_i;
      end
      s_nxt.len = TRC_FIXED_LEN + trace_data_len(trc_code_i);
      s_nxt.pos = POS_DELIM;
      s_nxt.sum = 8'h00;
      if (!verbose_join_option_i)
      begin
        s_nxt.phase = PH_IDLE;
      end
      else if (command_mode_i)
      begin
        s_nxt.phase = PH_TEXT;
      end
      else
      begin
        s_nxt.phase = PH_FRAME;
      end
    end
    else if (fill_s.valid && fill_s.ready)
    begin
      s_nxt.pos = s_r.pos + 8'h01;
      if (s_r.phase == PH_TEXT)
      begin
        if (text_last)
        begin
          s_nxt.phase = PH_IDLE;
        end
      end
      else
      begin
        if (s_r.pos >= POS_TYPE && s_r.pos != last_pos)
        begin
          s_nxt.sum = s_r.sum + cur_byte;
        end
        if (s_r.pos == last_pos)
        begin
          s_nxt.phase = PH_IDLE;
        end
      end
    end

    // the two requesters are offered the idle slot in turn
    s_nxt.rsp_ready = (s_nxt.phase == PH_IDLE) && !s_nxt.offer_trc;
    s_nxt.trc_ready = (s_nxt.phase == PH_IDLE) && s_nxt.offer_trc;

    // output register in front of the host link
    if (drain_s.valid && drain_s.ready)
    begin
      s_nxt.tx_valid = 1'b1;
      s_nxt.tx_data = drain_s.data;
    end
    else if (tx_ready_i)
    begin
      s_nxt.tx_valid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

endmodule : remote_response_status_framer

/* File: framer_pkg.sv */
// constants, codes and types shared by the outbound frame builder
package framer_pkg;

  localparam logic [7:0] START_DELIM = 8'h7e;
  localparam logic [7:0] TYPE_REMOTE_REQ = 8'h17;
  localparam logic [7:0] TYPE_REMOTE_RSP = 8'h97;
  localparam logic [7:0] TYPE_TRACE = 8'h98;
  localparam logic [7:0] CSUM_BASE = 8'hff;
  localparam logic [15:0] ADDR16_UNKNOWN = 16'hfffe;

  // byte positions inside a frame
  localparam logic [7:0] POS_DELIM = 8'h00;
  localparam logic [7:0] POS_LEN_MSB = 8'h01;
  localparam logic [7:0] POS_LEN_LSB = 8'h02;
  localparam logic [7:0] POS_TYPE = 8'h03;
  localparam logic [7:0] POS_FRAME_ID = 8'h04;
  localparam logic [7:0] POS_ADDR64_LSB = 8'h0c;
  localparam logic [7:0] POS_ADDR16_MSB = 8'h0d;
  localparam logic [7:0] POS_ADDR16_LSB = 8'h0e;
  localparam logic [7:0] POS_NAME_HI = 8'h0f;
  localparam logic [7:0] POS_NAME_LO = 8'h10;
  localparam logic [7:0] POS_STATUS = 8'h11;
  localparam logic [7:0] POS_RSP_DATA = 8'h12;
  localparam logic [7:0] POS_TRC_DATA = 8'h05;
  localparam logic [7:0] HDR_BYTES = 8'h03;
  localparam logic [15:0] RSP_FIXED_LEN = 16'h000f;
  localparam logic [15:0] TRC_FIXED_LEN = 16'h0002;

  // command outcome byte
  localparam logic [7:0] CMD_OK = 8'h00;
  localparam logic [7:0] CMD_ERROR = 8'h01;
  localparam logic [7:0] CMD_UNKNOWN = 8'h02;
  localparam logic [7:0] CMD_BAD_PARAM = 8'h03;
  localparam logic [7:0] CMD_TX_FAILED = 8'h04;

  // trace status codes, stack states and network events
  localparam logic [7:0] TRC_JOIN_START = 8'h00;
  localparam logic [7:0] TRC_STACK_STATUS = 8'h01;
  localparam logic [7:0] STACK_NO_NETWORK = 8'h00;
  localparam logic [7:0] STACK_JOINING = 8'h01;
  localparam logic [7:0] STACK_JOINED = 8'h02;
  localparam logic [7:0] STACK_JOINED_NO_PARENT = 8'h03;
  localparam logic [7:0] STACK_LEAVING = 8'h04;
  localparam logic [7:0] NET_UP = 8'h90;
  localparam logic [7:0] NET_DOWN = 8'h91;
  localparam logic [7:0] NET_JOIN_FAILED = 8'h94;
  localparam logic [7:0] NET_MOVE_FAILED = 8'h96;
  localparam logic [7:0] NET_ROUTER_INCOMPAT = 8'h98;
  localparam logic [7:0] NET_ID_CHANGED = 8'h99;
  localparam logic [7:0] NET_PAN_CHANGED = 8'h9a;
  localparam logic [7:0] NET_CHANNEL_CHANGED = 8'h9b;
  localparam logic [7:0] NET_NO_BEACONS = 8'hab;

  // readable strings, right aligned, for command mode
  localparam int TXT_W = 16;
  localparam logic [8*TXT_W-1:0] TXT_JOIN_START = "Rejoin\r\n";
  localparam logic [7:0] TXT_JOIN_START_LEN = 8'h08;
  localparam logic [8*TXT_W-1:0] TXT_STACK_STATUS = "Stack Status\r\n";
  localparam logic [7:0] TXT_STACK_STATUS_LEN = 8'h0e;
  localparam logic [8*TXT_W-1:0] TXT_OTHER = "Status\r\n";
  localparam logic [7:0] TXT_OTHER_LEN = 8'h08;

  typedef enum logic [1:0] {PH_IDLE, PH_FRAME, PH_TEXT} phase_e;

  // status data bytes carried by each trace code
  function automatic logic [15:0] trace_data_len(input logic [7:0] code);
    logic [15:0] n;
    n = 16'h0000;
    if (code == TRC_JOIN_START)
    begin
      n = 16'h0001;
    end
    else if (code == TRC_STACK_STATUS)
    begin
      n = 16'h0002;
    end
    return n;
  endfunction : trace_data_len

endpackage : framer_pkg

/* File: byte_stream_if.sv */
// valid/ready byte stream between the framer and its fifo
interface byte_stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : byte_stream_if

/* File: byte_fifo.sv */
// parameterised fifo with valid/ready on both sides
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  byte_stream_if.snk in_s,
  byte_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] cnt;
  } fifo_s;

  fifo_s s_r;
  fifo_s s_nxt;
  logic push;
  logic pop;

  assign in_s.ready = (s_r.cnt != FULL_CNT);
  assign out_s.valid = (s_r.cnt != '0);
  assign out_s.data = s_r.mem[s_r.rd];

  always_comb
  begin
    s_nxt = s_r;
    push = in_s.valid && in_s.ready;
    pop = out_s.valid && out_s.ready;
    if (push)
    begin
      s_nxt.mem[s_r.wr] = in_s.data;
      s_nxt.wr = (s_r.wr == LAST_PTR) ? '0 : s_r.wr + 1'b1;
    end
    if (pop)
    begin
      s_nxt.rd = (s_r.rd == LAST_PTR) ? '0 : s_r.rd + 1'b1;
    end
    if (push && !pop)
    begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

endmodule : byte_fifo

/* File: trace_text_rom.sv */
// readable strings for trace codes shown in command mode
module trace_text_rom
  import framer_pkg::*;
(
  input wire logic [7:0] code_i,
  input wire logic [7:0] index_i,
  output logic [7:0] char_o,
  output logic last_o
);
  logic [8*TXT_W-1:0] txt;
  logic [7:0] len;

  always_comb
  begin
    if (code_i == TRC_JOIN_START)
    begin
      txt = TXT_JOIN_START;
      len = TXT_JOIN_START_LEN;
    end
    else if (code_i == TRC_STACK_STATUS)
    begin
      txt = TXT_STACK_STATUS;
      len = TXT_STACK_STATUS_LEN;
    end
    else
    begin
      txt = TXT_OTHER;
      len = TXT_OTHER_LEN;
    end
    char_o = txt[8*(len - 8'h01 - index_i) +: 8];
    last_o = (index_i == len - 8'h01);
  end

endmodule : trace_text_rom

/* File: host_sink.sv */
// host end of the serial byte stream: takes bytes at once or with random stalls
module host_sink (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  output logic tx_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int seed = 55111;
  initial tx_ready_o = 1'b0;
  // a stalling host lets the fifo fill until the builder waits
  always @(posedge sys_clk_i)
    tx_ready_o <= rst_i ? 1'b0 : (!slow_i || ($random(seed) % 3 == 0));
endmodule : host_sink

/* File: framer_properties.sv */
// concurrent checks on the frame builder's ports
module framer_checker #(
  parameter int DATA_MAX = 32,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic rsp_valid_i,
  input wire logic rsp_ready_o,
  input wire logic [7:0] rsp_frame_id_i,
  input wire logic [15:0] rsp_addr16_i,
  input wire logic rsp_addr16_known_i,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_ready_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic acc;
  logic [7:0] pos_r, type_r, fid_r, sum_r;
  logic [15:0] len_r, a16_r, a16_pend;
  assign acc = tx_valid_o && tx_ready_i;
  // position of the accepted byte inside the current frame
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      pos_r <= 8'h00;
    else if (acc)
    begin
      pos_r <= pos_r + 8'h01;
      if (pos_r == 8'h00 && tx_data_o != 8'h7e)
        pos_r <= 8'h00;
      if (pos_r > 8'h03 && {8'h00, pos_r} == len_r + 16'h0003)
        pos_r <= 8'h00;
      if (pos_r == 8'h01)
        len_r[15:8] <= tx_data_o;
      if (pos_r == 8'h02)
        len_r[7:0] <= tx_data_o;
      if (pos_r == 8'h03)
        type_r <= tx_data_o;
      // a later take may land while this frame's tail still waits in the fifo
      if (pos_r == 8'h04)
        a16_r <= a16_pend;
      sum_r <= (pos_r == 8'h03) ? tx_data_o : sum_r + tx_data_o;
    end
    if (rsp_valid_i && rsp_ready_o)
    begin
      fid_r <= rsp_frame_id_i;
      a16_pend <= rsp_addr16_known_i ? rsp_addr16_i : 16'hfffe;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("stream byte changed before acceptance");
  len_high_a: assert property (acc && pos_r == 8'h01 |-> tx_data_o == 8'h00)
    else $error("length high byte not zero");
  frame_type_a: assert property (acc && pos_r == 8'h03 |-> tx_data_o inside {8'h97, 8'h98})
    else $error("unexpected frame type");
  frame_sum_a: assert property (acc && pos_r > 8'h03 && {8'h00, pos_r} == len_r + 16'h0003 |->
    8'(sum_r + tx_data_o) == 8'hff)
    else $error("bad checksum byte");
  fid_echo_a: assert property (acc && pos_r == 8'h04 && type_r == 8'h97 |-> tx_data_o == fid_r)
    else $error("frame id not echoed");
  net_addr_a: assert property (acc && pos_r inside {8'h0d, 8'h0e} && type_r == 8'h97 |->
    tx_data_o == (pos_r == 8'h0d ? a16_r[15:8] : a16_r[7:0]))
    else $error("network address bytes wrong");
  trc_len_a: assert property (acc && pos_r == 8'h04 && type_r == 8'h98 |->
    len_r == 16'h0002 + (tx_data_o == 8'h00 ? 16'h0001 : tx_data_o == 8'h01 ? 16'h0002 : 16'h0000))
    else $error("trace length does not match code");
  rsp_busy_a: assert property (rsp_valid_i && rsp_ready_o |=> !rsp_ready_o [*8])
    else $error("response taken again during a frame");
endmodule : framer_checker

bind remote_response_status_framer framer_checker #(.DATA_MAX(DATA_MAX), .FIFO_DEPTH(FIFO_DEPTH))
  i_framer_checker (.sys_clk_i, .rst_i, .rsp_valid_i, .rsp_ready_o, .rsp_frame_id_i,
  .rsp_addr16_i, .rsp_addr16_known_i, .tx_valid_o, .tx_data_o, .tx_ready_i);

/* File: tb.sv */
// self-checking bench for the remote response and join trace frame builder
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import framer_pkg::*;
  localparam int DMAX = 32;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic verbose_join_option_i = 1'b0, command_mode_i = 1'b0, rsp_valid_i = 1'b0;
  logic rsp_addr16_known_i = 1'b0, rsp_was_write_i = 1'b0, trc_valid_i = 1'b0, slow = 1'b0;
  logic rsp_ready_o, trc_ready_o, tx_valid_o, tx_ready_i;
  logic [7:0] rsp_frame_id_i = 8'h00, rsp_status_i = 8'h00, rsp_data_len_i = 8'h00;
  logic [7:0] trc_code_i = 8'h00, join_attempt_count_i = 8'h00, stack_state_byte_i = 8'h00;
  logic [7:0] network_event_byte_i = 8'h00, tx_data_o;
  logic [63:0] rsp_addr64_i = 64'h0;
  logic [15:0] rsp_addr16_i = 16'h0, rsp_cmd_name_i = 16'h0;
  logic [8*DMAX-1:0] rsp_data_i = '0;
  logic [7:0] exp_q[$], body_q[$];
  logic [7:0] events[9] = '{8'h90, 8'h91, 8'h94, 8'h96, 8'h98, 8'h99, 8'h9a, 8'h9b, 8'hab};
  int seed = 55111;
  int fail_count = 0;
  int checked = 0;

  always #4 sys_clk_i = ~sys_clk_i;

  remote_response_status_framer #(.DATA_MAX(DMAX), .FIFO_DEPTH(8)) i_remote_response_status_framer (
    .sys_clk_i, .rst_i, .verbose_join_option_i, .command_mode_i, .rsp_valid_i, .rsp_ready_o,
    .rsp_frame_id_i, .rsp_addr64_i, .rsp_addr16_i, .rsp_addr16_known_i, .rsp_cmd_name_i,
    .rsp_status_i, .rsp_was_write_i, .rsp_data_len_i, .rsp_data_i, .trc_valid_i, .trc_ready_o,
    .trc_code_i, .join_attempt_count_i, .stack_state_byte_i, .network_event_byte_i,
    .tx_valid_o, .tx_data_o, .tx_ready_i);
  host_sink i_host_sink (.sys_clk_i, .rst_i, .slow_i(slow), .tx_ready_o(tx_ready_i));

  task automatic check_eq(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check_eq

  task automatic print_verdict();
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // wraps body_q in delimiter, length and checksum
  task automatic emit();
    logic [7:0] s;
    s = 8'h00;
    exp_q.push_back(8'h7e);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'(body_q.size()));
    foreach (body_q[i])
    begin
      exp_q.push_back(body_q[i]);
      s += body_q[i];
    end
    exp_q.push_back(8'hff - s);
    body_q.delete();
  endtask : emit

  // ready is read at the falling edge, the take happens at the next rising edge
  task automatic wait_turn(input bit trc);
    int n;
    n = 0;
    do
    begin
      @(negedge sys_clk_i);
      n++;
    end
    while ((trc ? trc_ready_o : rsp_ready_o) !== 1'b1 && n < 500);
    if (n >= 500)
      fail_count++;
    @(posedge sys_clk_i);
  endtask : wait_turn

  task automatic send_rsp(input int k);
    logic [119:0] hdr;
    int n;
    @(posedge sys_clk_i);
    rsp_frame_id_i <= (k % 4 == 1) ? rsp_frame_id_i : 8'($random(seed));
    rsp_addr64_i <= {$random(seed), $random(seed)};
    rsp_addr16_i <= 16'($random(seed));
    rsp_addr16_known_i <= k[0];
    rsp_cmd_name_i <= 16'($random(seed));
    rsp_status_i <= 8'(k % 5);
    rsp_was_write_i <= (k % 3 == 2);
    rsp_data_len_i <= 8'(k * 5);
    rsp_data_i <= {8{$random(seed)}};
    rsp_valid_i <= 1'b1;
    wait_turn(1'b0);
    rsp_valid_i <= 1'b0;
    n = rsp_was_write_i ? 0 : (rsp_data_len_i > DMAX ? DMAX : int'(rsp_data_len_i));
    hdr = {8'h97, rsp_frame_id_i, rsp_addr64_i, rsp_addr16_known_i ? rsp_addr16_i : 16'hfffe,
      rsp_cmd_name_i, rsp_status_i};
    for (int i = 14; i >= 0; i--)
      body_q.push_back(hdr[8*i+:8]);
    for (int i = 0; i < n; i++)
      body_q.push_back(rsp_data_i[8*i+:8]);
    emit();
  endtask : send_rsp

  task automatic send_trc(input int k);
    logic [8*TXT_W-1:0] t;
    int l;
    @(posedge sys_clk_i);
    trc_code_i <= (k % 3 == 2) ? 8'h0c : 8'(k % 3);
    verbose_join_option_i <= (k % 7 != 5);
    command_mode_i <= (k % 11 == 10);
    join_attempt_count_i <= 8'($random(seed));
    stack_state_byte_i <= 8'(k % 5);
    network_event_byte_i <= events[(k / 3) % 9];
    trc_valid_i <= 1'b1;
    wait_turn(1'b1);
    trc_valid_i <= 1'b0;
    if (!verbose_join_option_i)
      return;
    if (command_mode_i)
    begin
      t = trc_code_i == 8'h00 ? TXT_JOIN_START : trc_code_i == 8'h01 ? TXT_STACK_STATUS : TXT_OTHER;
      l = trc_code_i == 8'h00 ? 8 : trc_code_i == 8'h01 ? 14 : 8;
      for (int i = l - 1; i >= 0; i--)
        exp_q.push_back(t[8*i+:8]);
      return;
    end
    body_q = '{8'h98, trc_code_i};
    if (trc_code_i == 8'h00)
      body_q.push_back(join_attempt_count_i);
    if (trc_code_i == 8'h01)
      body_q = {body_q, stack_state_byte_i, network_event_byte_i};
    emit();
  endtask : send_trc

  // byte shown before a rising edge with ready high is taken at that edge
  always @(negedge sys_clk_i)
    if (!rst_i && tx_valid_o === 1'b1 && tx_ready_i === 1'b1)
      check_eq("tx byte", tx_data_o, exp_q.size() ? exp_q.pop_front() : 8'hxx);

  initial
  begin
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    for (int p = 0; p < 2; p++)
    begin
      slow <= p[0];
      fork
        for (int k = 0; k < 15; k++)
          send_rsp(k);
        for (int k = 0; k < 45; k++)
          send_trc(k);
      join
    end
    for (int i = 0; i < 3000 && exp_q.size() != 0; i++)
      @(posedge sys_clk_i);
    repeat (20) @(posedge sys_clk_i);
    check_eq("bytes left", 8'(exp_q.size()), 8'h00);
    print_verdict();
  end

  initial
  begin
    repeat (40000) @(posedge sys_clk_i);
    fail_count++;
    print_verdict();
  end
endmodule : tb
